// >>> logic/pco_core.sv
// Operation
// - MSI-X needs an enabled memory BAR
// - BAR indicator names lower dword of 64-bit
// - PM capability advertises device-specific initialization flag
// - PME support gates the wake request
// - D3hot to D0 keeps all context
// - Power budget and dissipation read 0W
// - VC and vendor caps need serial number
// - VC enables TCn/VC0 traffic class filtering
// - Root port may reject unset no-snoop
// - Legacy user space routes config to user
// - Legacy pointer lies within 2Ah to 3Fh
// - Extended requests at/above pointer go user
// - AER keeps a single header only
// - Root status, source ID zero unless permitted
// - Unselected optional errors hardwired zero
// - ECRC check encoding 0, 1, 3
// - Trim clears TD and strips ECRC
// - Poisoned config write: parity, UR completion
// - Poisoned memory write masked: parity, no TLP
// - Unmasked poisoned memory write sends message
// - Suppressed: message only on user report
`timescale 1ns/1ps
`include "pco_map.svh"
module pco_core
  import pco_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Received request, one cycle per request
  input  wire logic        rx_valid,
  input  wire logic [1:0]  rx_kind,
  input  wire logic        rx_poisoned,
  input  wire logic        rx_td,
  input  wire logic        rx_ecrc_bad,
  input  wire logic [9:0]  rx_dw_addr,
  input  wire logic [2:0]  rx_tc,
  input  wire logic        rx_ns_applic,
  input  wire logic        rx_ns_set,
  input  wire logic [15:0] rx_req_id,
  // Decision, one cycle after the request
  output logic             fwd_valid,
  output logic             fwd_td,
  output logic             fwd_strip_ecrc,
  output logic             fwd_cfg_user,
  output logic             cfg_internal,
  output logic             ur_cpl,
  output logic             ecrc_drop,
  output logic             err_msg,
  // User side
  input  wire logic [63:0] dsn_in,
  input  wire logic        poisoned_err_report_in,
  input  wire logic        pm_wake_request_in,
  input  wire logic [2:0]  pm_state,
  output logic             pm_wake_out,
  output logic             msix_active,
  output logic             vc_active,
  output logic             vsec_active
);

  pco_bus_t    bus_q;
  logic [7:0]  addr_q;
  logic [31:0] ctrl_q;
  logic [31:0] msix_q;
  logic [31:0] ptr_q;
  logic [31:0] aeropt_q;
  logic [31:0] umask_q;
  logic [31:0] usev_q;
  logic [31:0] cmask_q;
  logic        rstat_q;
  logic [15:0] esrc_q;
  logic        par_q;
  logic        ecrc_q;
  logic [31:0] rd_d;
  logic        accept;
  logic        wr_en;

  assign accept = hsel & hready & htrans[1];
  assign wr_en  = (bus_q == PCO_BUS_WR);

  // Bus phases: writes take no wait state, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q     <= PCO_BUS_IDLE;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        PCO_BUS_RD: begin
          bus_q     <= PCO_BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= rd_d;
        end
        default: begin
          if (accept) begin
            addr_q    <= {haddr[7:2], 2'b00};
            bus_q     <= hwrite ? PCO_BUS_WR : PCO_BUS_RD;
            hreadyout <= hwrite;
          end else begin
            bus_q <= PCO_BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Configuration writes; an unmapped write is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= `PCO_CTRL_RST;
      msix_q   <= 32'h0000_0000;
      ptr_q    <= `PCO_PTR_RST;
      aeropt_q <= 32'h0000_0000;
      umask_q  <= 32'h0000_0000;
      usev_q   <= 32'h0000_0000;
      cmask_q  <= 32'h0000_0000;
    end else begin
      if (wr_en && addr_q == `PCO_CTRL_OFF) begin
        ctrl_q <= hwdata;
      end
      if (wr_en && addr_q == `PCO_MSIX_OFF) begin
        msix_q <= hwdata;
      end
      if (wr_en && addr_q == `PCO_PTR_OFF) begin
        ptr_q <= hwdata;
      end
      if (wr_en && addr_q == `PCO_AEROPT_OFF) begin
        aeropt_q <= hwdata;
        umask_q  <= umask_q & hwdata;
        usev_q   <= usev_q & hwdata;
        cmask_q  <= cmask_q & hwdata;
      end
      if (wr_en && addr_q == `PCO_UMASK_OFF) begin
        umask_q <= hwdata & aeropt_q;
      end
      if (wr_en && addr_q == `PCO_USEV_OFF) begin
        usev_q <= hwdata & aeropt_q;
      end
      if (wr_en && addr_q == `PCO_CMASK_OFF) begin
        cmask_q <= hwdata & aeropt_q;
      end
    end
  end

  // Decoded options
  logic       dsn_en;
  logic       pois_off;
  logic       adv_nf;
  logic       permit;
  logic [1:0] ecrc_mode;
  logic [4:0] pme_sup;
  logic [7:0] tc_map;
  logic [5:0] leg_ptr;
  logic [9:0] ext_ptr;
  logic [2:0] tbir;
  logic [2:0] pbir;
  logic [5:0] bar_en;
  logic [5:0] bar64;

  assign dsn_en    = ctrl_q[`PCO_C_DSN];
  assign pois_off  = ctrl_q[`PCO_C_NOPOIS];
  assign adv_nf    = ctrl_q[`PCO_C_ADVNF];
  assign permit    = ctrl_q[`PCO_C_ROOTUPD];
  assign ecrc_mode = ctrl_q[`PCO_C_ECRC_LSB +: 2];
  assign pme_sup   = ctrl_q[`PCO_C_PME_LSB +: 5];
  assign tc_map    = ctrl_q[`PCO_C_TC_LSB +: 8];
  assign tbir      = msix_q[`PCO_M_TBIR_LSB +: 3];
  assign pbir      = msix_q[`PCO_M_PBIR_LSB +: 3];
  assign bar_en    = msix_q[`PCO_M_BEN_LSB +: 6];
  assign bar64     = msix_q[`PCO_M_B64_LSB +: 6];
  assign ext_ptr   = ptr_q[`PCO_P_EXT_LSB +: 10];

  // Pointer below the legal window is raised to its floor
  assign leg_ptr = (ptr_q[`PCO_P_LEG_LSB +: 6] < `PCO_LEG_MIN) ?
                   `PCO_LEG_MIN : ptr_q[`PCO_P_LEG_LSB +: 6];

  // Upper half of a 64-bit pair resolves to its lower dword
  function automatic logic [2:0] lower_bar(input logic [2:0] bir, input logic [5:0] b64);
    logic [2:0] lo;
    lo = bir - 3'h1;
    if (bir != 3'h0 && bir < 3'h6 && b64[lo]) begin
      lower_bar = lo;
    end else begin
      lower_bar = bir;
    end
  endfunction

  logic [2:0] tbar;
  logic [2:0] pbar;
  logic       tbar_ok;
  logic       pbar_ok;

  assign tbar    = lower_bar(tbir, bar64);
  assign pbar    = lower_bar(pbir, bar64);
  assign tbar_ok = (tbar < 3'h6) && bar_en[tbar];
  assign pbar_ok = (pbar < 3'h6) && bar_en[pbar];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msix_active <= 1'b0;
      vc_active   <= 1'b0;
      vsec_active <= 1'b0;
    end else begin
      msix_active <= ctrl_q[`PCO_C_MSIX] & tbar_ok & pbar_ok;
      vc_active   <= ctrl_q[`PCO_C_VC] & dsn_en;
      vsec_active <= ctrl_q[`PCO_C_VSEC] & dsn_en;
    end
  end

  // Wake is passed only from states listed as PME capable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pm_wake_out <= 1'b0;
    end else begin
      pm_wake_out <= pm_wake_request_in & (pm_state < `PCO_PM_NSTATES) &
                     pme_sup[pm_state];
    end
  end

  // Request classification
  logic ecrc_chk;
  logic ecrc_fail;
  logic is_cfg;
  logic cfg_user;
  logic rej;
  logic pois_cw;
  logic pois_mw;
  logic good;
  logic auto_msg;

  always_comb begin
    unique case (pco_ecrc_t'(ecrc_mode))
      PCO_ECRC_ALWAYS: ecrc_chk = 1'b1;
      PCO_ECRC_AER:    ecrc_chk = ctrl_q[`PCO_C_ECRCEN];
      default:         ecrc_chk = 1'b0;
    endcase
  end

  assign ecrc_fail = rx_valid & rx_td & rx_ecrc_bad & ecrc_chk;
  assign is_cfg    = (rx_kind == PCO_K_CFGRD) | (rx_kind == PCO_K_CFGWR);
  assign cfg_user  = is_cfg &
    (((rx_dw_addr < `PCO_COMPAT_END) & ctrl_q[`PCO_C_LEGEN] &
      (rx_dw_addr >= {4'h0, leg_ptr})) |
     ((rx_dw_addr >= `PCO_COMPAT_END) & ctrl_q[`PCO_C_EXTEN] &
      (rx_dw_addr >= ext_ptr)));
  assign rej = (ctrl_q[`PCO_C_RP] & ctrl_q[`PCO_C_NOSNP] &
                rx_ns_applic & ~rx_ns_set) |
               (vc_active & ~tc_map[rx_tc]);
  assign pois_cw  = rx_poisoned & (rx_kind == PCO_K_CFGWR);
  assign pois_mw  = rx_poisoned & (rx_kind == PCO_K_MEMWR);
  assign good     = rx_valid & ~ecrc_fail;
  assign auto_msg = good & pois_mw & ~adv_nf & ~pois_off;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_valid      <= 1'b0;
      fwd_td         <= 1'b0;
      fwd_strip_ecrc <= 1'b0;
      fwd_cfg_user   <= 1'b0;
      cfg_internal   <= 1'b0;
      ur_cpl         <= 1'b0;
      ecrc_drop      <= 1'b0;
    end else begin
      fwd_valid      <= good & ~pois_cw & ~pois_mw & ~rej & (~is_cfg | cfg_user);
      fwd_td         <= rx_td & ~ctrl_q[`PCO_C_TRIM];
      fwd_strip_ecrc <= rx_td & ctrl_q[`PCO_C_TRIM];
      fwd_cfg_user   <= good & cfg_user & ~pois_cw & ~rej;
      cfg_internal   <= good & is_cfg & ~cfg_user & ~pois_cw & ~rej;
      ur_cpl         <= good & (pois_cw | rej) & (rx_kind != PCO_K_MEMWR);
      ecrc_drop      <= ecrc_fail;
    end
  end

  // Messages: automatic, or only on the user report when suppressed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_msg <= 1'b0;
    end else begin
      err_msg <= auto_msg | (pois_off & poisoned_err_report_in);
    end
  end

  // Sticky status; a set in the same cycle as a clear wins
  logic par_set;
  logic stat_clr;
  logic rstat_clr;

  assign par_set   = good & (pois_cw | pois_mw);
  assign stat_clr  = wr_en && addr_q == `PCO_STAT_OFF;
  assign rstat_clr = wr_en && addr_q == `PCO_RSTAT_OFF && hwdata[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      par_q  <= 1'b0;
      ecrc_q <= 1'b0;
    end else begin
      par_q  <= (par_q & ~(stat_clr & hwdata[`PCO_S_PAR])) | par_set;
      ecrc_q <= (ecrc_q & ~(stat_clr & hwdata[`PCO_S_ECRC])) | ecrc_fail;
    end
  end

  // One header log entry: a new error overwrites the single slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rstat_q <= 1'b0;
      esrc_q  <= 16'h0000;
    end else if (!permit) begin
      rstat_q <= 1'b0;
      esrc_q  <= 16'h0000;
    end else begin
      rstat_q <= (rstat_q & ~rstat_clr) | auto_msg;
      if (auto_msg) begin
        esrc_q <= rx_req_id;
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (addr_q)
      `PCO_CTRL_OFF:   rd_d = ctrl_q;
      `PCO_MSIX_OFF:   rd_d = msix_q;
      `PCO_PTR_OFF:    rd_d = {ptr_q[31:6], leg_ptr};
      `PCO_AEROPT_OFF: rd_d = aeropt_q;
      `PCO_UMASK_OFF:  rd_d = umask_q;
      `PCO_USEV_OFF:   rd_d = usev_q;
      `PCO_CMASK_OFF:  rd_d = cmask_q;
      `PCO_RSTAT_OFF:  rd_d = {31'h0, rstat_q & permit};
      `PCO_ESRC_OFF:   rd_d = {16'h0000, esrc_q & {16{permit}}};
      `PCO_STAT_OFF:   rd_d = {27'h0, vsec_active, vc_active, msix_active, ecrc_q, par_q};
      // Context is cleared only by hresetn, never by a D3hot to D0 change
      `PCO_PMCAP_OFF:  rd_d = {`PCO_PM_DATA, 4'h0, 1'b1, 3'h0,
                               pme_sup, 5'h00, ctrl_q[`PCO_C_DSI],
                               2'b00, `PCO_PM_VER};
      `PCO_SNLO_OFF:   rd_d = dsn_in[31:0] & {32{dsn_en}};
      `PCO_SNHI_OFF:   rd_d = dsn_in[63:32] & {32{dsn_en}};
      default:         rd_d = 32'h0000_0000;
    endcase
  end

endmodule // pco_core

// >>> logic/pco_map.svh
`ifndef PCO_MAP_SVH
`define PCO_MAP_SVH
// Register byte offsets
`define PCO_CTRL_OFF   8'h00
`define PCO_MSIX_OFF   8'h04
`define PCO_PTR_OFF    8'h08
`define PCO_AEROPT_OFF 8'h0c
`define PCO_UMASK_OFF  8'h10
`define PCO_USEV_OFF   8'h14
`define PCO_CMASK_OFF  8'h18
`define PCO_RSTAT_OFF  8'h1c
`define PCO_ESRC_OFF   8'h20
`define PCO_STAT_OFF   8'h24
`define PCO_PMCAP_OFF  8'h28
`define PCO_SNLO_OFF   8'h2c
`define PCO_SNHI_OFF   8'h30
// Control register fields
`define PCO_C_MSIX     0
`define PCO_C_DSN      1
`define PCO_C_VC       2
`define PCO_C_VSEC     3
`define PCO_C_DSI      4
`define PCO_C_LEGEN    5
`define PCO_C_EXTEN    6
`define PCO_C_ROOTUPD  7
`define PCO_C_TRIM     8
`define PCO_C_NOPOIS   9
`define PCO_C_ADVNF    10
`define PCO_C_ECRCEN   11
`define PCO_C_RP       12
`define PCO_C_NOSNP    13
`define PCO_C_ECRC_LSB 14
`define PCO_C_PME_LSB  16
`define PCO_C_TC_LSB   24
`define PCO_CTRL_RST   32'h0100_0400
// MSI-X placement fields
`define PCO_M_TBIR_LSB 0
`define PCO_M_PBIR_LSB 3
`define PCO_M_BEN_LSB  6
`define PCO_M_B64_LSB  12
// Pointer fields and limits
`define PCO_P_LEG_LSB  0
`define PCO_P_EXT_LSB  16
`define PCO_PTR_RST    32'h0040_002a
`define PCO_LEG_MIN    6'h2a
`define PCO_COMPAT_END 10'h040
// Power management constants
`define PCO_PM_VER     3'h3
`define PCO_PM_DATA    8'h00
`define PCO_PM_NSTATES 3'h5
// Status bits
`define PCO_S_PAR      0
`define PCO_S_ECRC     1
`endif

// >>> logic/pco_pkg.sv
package pco_pkg;
  typedef enum logic [1:0] {
    PCO_K_CFGRD = 2'h0,
    PCO_K_CFGWR = 2'h1,
    PCO_K_MEMWR = 2'h2,
    PCO_K_OTHER = 2'h3
  } pco_kind_t;
  typedef enum logic [1:0] {
    PCO_ECRC_NEVER  = 2'h0,
    PCO_ECRC_ALWAYS = 2'h1,
    PCO_ECRC_RSVD   = 2'h2,
    PCO_ECRC_AER    = 2'h3
  } pco_ecrc_t;
  typedef enum logic [1:0] {
    PCO_BUS_IDLE = 2'b00,
    PCO_BUS_WR   = 2'b01,
    PCO_BUS_RD   = 2'b11
  } pco_bus_t;
endpackage

// >>> tb/pco_core_chk.sv
`timescale 1ns/1ps
`include "pco_map.svh"
module pco_core_chk
  import pco_pkg::*;
(
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Request and decision
  input wire logic        rx_valid,
  input wire logic [1:0]  rx_kind,
  input wire logic        rx_poisoned,
  input wire logic        rx_td,
  input wire logic        rx_ecrc_bad,
  input wire logic        fwd_valid,
  input wire logic        fwd_td,
  input wire logic        fwd_strip_ecrc,
  input wire logic        ur_cpl,
  input wire logic        ecrc_drop,
  input wire logic        err_msg,
  // User side
  input wire logic        poisoned_err_report_in,
  input wire logic        pm_wake_request_in,
  input wire logic [2:0]  pm_state,
  input wire logic        pm_wake_out,
  input wire logic        vc_active,
  input wire logic        vsec_active
);
  logic [31:0] ctl_q;
  logic        wr_q;
  logic        pois;
  logic        wake;
  // Shadow of the control register, taken from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      ctl_q <= `PCO_CTRL_RST;
    end else begin
      if (hready) wr_q <= hsel && htrans[1] && hwrite && haddr == `PCO_CTRL_OFF;
      if (wr_q && hready) ctl_q <= hwdata;
    end
  end
  assign pois = rx_valid && rx_poisoned && !(rx_td && rx_ecrc_bad) && !poisoned_err_report_in;
  assign wake = pm_wake_request_in && pm_state < 3'h5 && ctl_q[`PCO_C_PME_LSB + pm_state];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_trim_strip: assert property (rx_valid && rx_td && ctl_q[`PCO_C_TRIM] |=>
    fwd_strip_ecrc && !fwd_td) else $error("digest kept while trimming");
  chk_ecrc_never: assert property (rx_valid && ctl_q[`PCO_C_ECRC_LSB +: 2] == 2'h0 |=>
    !ecrc_drop) else $error("ecrc drop while checking is off");
  chk_ecrc_always: assert property (rx_valid && rx_td && rx_ecrc_bad &&
    ctl_q[`PCO_C_ECRC_LSB +: 2] == 2'h1 |=> ecrc_drop && !fwd_valid) else $error("bad ecrc passed");
  chk_pois_cfg: assert property (pois && rx_kind == PCO_K_CFGWR && ctl_q[`PCO_C_ADVNF] |=>
    ur_cpl && !fwd_valid) else $error("poisoned config write not refused");
  chk_pois_mem: assert property (pois && rx_kind == PCO_K_MEMWR && ctl_q[`PCO_C_ADVNF] |=>
    !fwd_valid && !ur_cpl && !err_msg) else $error("poisoned memory write answered");
  chk_pois_msg: assert property (pois && rx_kind == PCO_K_MEMWR && !ctl_q[`PCO_C_ADVNF] &&
    !ctl_q[`PCO_C_NOPOIS] |=> err_msg) else $error("no message for poisoned write");
  chk_user_rep: assert property (ctl_q[`PCO_C_NOPOIS] && poisoned_err_report_in |=>
    err_msg) else $error("user report gave no message");
  chk_no_auto: assert property (err_msg && ctl_q[`PCO_C_NOPOIS] && $past(ctl_q[`PCO_C_NOPOIS])
    |-> $past(poisoned_err_report_in)) else $error("message without user report");
  chk_wake_gate: assert property (1'b1 |=> pm_wake_out == $past(wake))
    else $error("wake output not gated by pme support");
  chk_vc_dsn: assert property (vc_active || vsec_active |-> $past(ctl_q[`PCO_C_DSN]))
    else $error("channel capability without serial number");
endmodule // pco_core_chk

bind pco_core pco_core_chk u_chk (.*);

// >>> tb/pco_user_model.sv
`timescale 1ns/1ps
module pco_user_model #(
  parameter logic [63:0] SERIAL = 64'h5a5a_0123_4567_89ab  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench controls
  input  wire logic        dsn_on,
  input  wire logic        rep_req,
  // Core user inputs
  output logic      [63:0] dsn_in,
  output logic             poisoned_err_report_in
);
  // Serial shown while enabled, a toggling pattern otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsn_in                 <= 64'h0;
      poisoned_err_report_in <= 1'b0;
    end else begin
      dsn_in                 <= dsn_on ? SERIAL : ~dsn_in;
      poisoned_err_report_in <= rep_req;
    end
  end
endmodule // pco_user_model

// >>> tb/test_pcie_capability_error_options.sv
`timescale 1ns/1ps
`include "pco_map.svh"
module test_pcie_capability_error_options;
  import pco_pkg::*;
  localparam logic [63:0] SERIAL = 64'h5a5a_0123_4567_89ab;  // Arbitrary value
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0, rx_kind = 2'h0;
  logic [2:0]  hsize = 3'h2, rx_tc = 3'h0, pm_state = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata, ctl = 32'h0100_0400, ptr = 32'h0040_002a;
  logic        hreadyout, hresp, rx_valid = 1'b0, rx_poisoned = 1'b0, rx_td = 1'b0;
  logic        rx_ecrc_bad = 1'b0, rx_ns_applic = 1'b0, rx_ns_set = 1'b0;
  logic [9:0]  rx_dw_addr = 10'h0;
  logic [15:0] rx_req_id = 16'h0;
  logic        fwd_valid, fwd_td, fwd_strip_ecrc, fwd_cfg_user, cfg_internal, ur_cpl;
  logic        ecrc_drop, err_msg, pm_wake_out, msix_active, vc_active, vsec_active;
  logic [63:0] dsn_in;
  logic        poisoned_err_report_in, pm_wake_request_in = 1'b0, rep_req = 1'b0;
  wire logic   hready = hreadyout;
  int          bad_count = 0, compares = 0, cyc = 0, n;

  pco_core dut (.*);
  pco_user_model #(.SERIAL(SERIAL)) um (.*, .dsn_on(ctl[1]));

  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  // Ready is a register, so its level late in the cycle is what the edge sees
  task automatic wait_rdy;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    chk(hrdata, e, w);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask
  // Expected {fwd_td, strip, fwd, user, internal, ur, drop, msg}
  function automatic logic [7:0] exp_dec();
    logic on, u;
    on = ctl[15:14] == 2'h1 || (ctl[15:14] == 2'h3 && ctl[11]);
    u = rx_dw_addr < 10'h040 ? ctl[5] && rx_dw_addr >= {4'h0, ptr[5:0]}
                             : ctl[6] && rx_dw_addr >= ptr[25:16];
    exp_dec = {rx_td && !ctl[8], rx_td && ctl[8], 6'h00};
    if (rx_td && rx_ecrc_bad && on) exp_dec[1] = 1'b1;
    else if (rx_poisoned && rx_kind == PCO_K_CFGWR) exp_dec[2] = 1'b1;
    else if (rx_poisoned && rx_kind == PCO_K_MEMWR) exp_dec[0] = !ctl[10] && !ctl[9];
    else if ((ctl[12] && ctl[13] && rx_ns_applic && !rx_ns_set) || (ctl[2] && ctl[1]
             && !ctl[24 + rx_tc])) exp_dec[2] = rx_kind != PCO_K_MEMWR;
    else if (rx_kind[1] == 1'b0) exp_dec[5:3] = u ? 3'b110 : 3'b001;
    else exp_dec[5] = 1'b1;
  endfunction
  task automatic send(input logic f);
    logic [20:0] r;
    r = 21'($urandom);
    if (f) r[20:17] = 4'b1010;
    {rx_kind, rx_poisoned, rx_td, rx_ecrc_bad, rx_dw_addr, rx_tc, rx_ns_applic, rx_ns_set,
     pm_wake_request_in} <= r;
    rx_req_id <= 16'($urandom);
    pm_state <= 3'($urandom_range(4, 0));
    rx_valid <= 1'b1;
    @(posedge hclk);
    rx_valid <= 1'b0;
    pm_wake_request_in <= 1'b0;
    #1;
    chk({24'h0, fwd_td, fwd_strip_ecrc, fwd_valid, fwd_cfg_user, cfg_internal, ur_cpl,
         ecrc_drop, err_msg}, {24'h0, exp_dec()}, "decision");
  endtask

  initial begin
    n = $urandom(94944);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`PCO_CTRL_OFF, 32'h0100_0400, "ctrl reset");
    rd_chk(8'hfc, 32'h0, "unmapped");
    wr(`PCO_PTR_OFF, 32'h0100_0010);
    rd_chk(`PCO_PTR_OFF, 32'h0100_002a, "pointer floor");
    $display("reset and pointer test done");
    wr(`PCO_AEROPT_OFF, 32'h0000_5a5a);
    for (int i = 0; i < 3; i++) begin
      wr(8'(16 + 4 * i), 32'hffff_ffff);
      rd_chk(8'(16 + 4 * i), 32'h0000_5a5a, "aer mask");
    end
    $display("aer mask test done");
    ctl = 32'h0100_0401;
    wr(`PCO_CTRL_OFF, ctl);
    wr(`PCO_MSIX_OFF, 32'h0000_1049);
    repeat (2) @(posedge hclk);
    chk({31'h0, msix_active}, 32'h1, "msix upper half");
    wr(`PCO_MSIX_OFF, 32'h0000_0049);
    repeat (2) @(posedge hclk);
    chk({31'h0, msix_active}, 32'h0, "msix without bar");
    $display("msix test done");
    ctl = 32'h0100_0000;
    for (int i = 0; i < 2; i++) begin
      wr(`PCO_CTRL_OFF, ctl);
      @(posedge hclk);
      send(1'b1);
      rd_chk(`PCO_RSTAT_OFF, {31'h0, ctl[7]}, "root status");
      rd_chk(`PCO_ESRC_OFF, ctl[7] ? {16'h0, rx_req_id} : 32'h0, "source id");
      ctl[7] = 1'b1;
    end
    $display("root status test done");
    ctl = 32'h0100_0200;
    wr(`PCO_CTRL_OFF, ctl);
    @(posedge hclk);
    send(1'b1);
    rep_req <= 1'b1;
    @(posedge hclk);
    rep_req <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge hclk);
      #1;
      n += int'(err_msg === 1'b1);
    end
    chk(32'(n), 32'h1, "user report");
    rd_chk(`PCO_STAT_OFF, 32'h1, "parity set");
    wr(`PCO_STAT_OFF, 32'h3);
    rd_chk(`PCO_STAT_OFF, 32'h0, "status clear");
    $display("user report test done");
    for (int b = 0; b < 12; b++) begin
      ctl = $urandom & 32'hff1f_ffff;
      ptr = {6'h0, 10'($urandom_range(1023, 64)), 10'h0, 6'($urandom_range(63, 42))};
      wr(`PCO_CTRL_OFF, ctl);
      wr(`PCO_PTR_OFF, ptr);
      @(posedge hclk);
      repeat (30) send(1'b0);
      rd_chk(`PCO_CTRL_OFF, ctl, "ctrl kept");
      rd_chk(`PCO_PTR_OFF, ptr, "pointers");
      rd_chk(`PCO_PMCAP_OFF, {12'h0, 1'b1, 3'h0, ctl[20:16], 5'h0, ctl[4], 5'h3}, "pm cap");
      rd_chk(`PCO_SNLO_OFF, ctl[1] ? SERIAL[31:0] : 32'h0, "serial");
      chk({30'h0, vc_active, vsec_active}, {30'h0, ctl[2] & ctl[1], ctl[3] & ctl[1]}, "gate");
    end
    $display("random test done");
    finish_test();
  end
endmodule // test_pcie_capability_error_options
